// ### bop_bus_options.sv
// Summary of operation
// [R1] Register value is served to remote bus readers as bus info quadlet one.
// [R2] Bits 31..28 hold writable resource, cycle master, isoch and bus manager flags.
// [R3] Bit 27 is a writable flag advertising power management support.
// [R4] Bits 23..16 hold writable cycle master clock accuracy in ppm.
// [R5] Software keeps capability, accuracy and max request valid while link active.
// [R6] Bits 15..12 hold max request code; bytes are 2^(code+1), at least 512.
// [R7] Hardware reset loads code for 2048 bytes; software reset keeps it.
// [R8] Oversized received block write may be answered with a type error acknowledge.
// [R9] Reserved bits 26..24, 11..8 and 5..3 read as zero.
// [R10] Bits 7..6 are writable generation, bumped when ROM changed since bus reset.
// [R11] Bits 2..0 read the constant 010 for 100, 200 and 400 Mbit/s.
// [R12] Writes to reserved bits and the link speed field are ignored.
`timescale 1ns/10ps
`include "bop_params.svh"

module bop_bus_options (
	// Clock and resets
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  soft_rst_i,
	// Register bus
	input  wire bop_pkg::bop_wb_req_t  wb_req_i,
	output      bop_pkg::bop_wb_rsp_t  wb_rsp_o,
	// Host controller state
	input  wire logic                  link_active_control_i,
	// Configuration ROM and bus events
	input  wire logic                  rom_change_i,
	input  wire logic                  bus_reset_i,
	// Remote bus info block read
	input  wire bop_pkg::bop_bib_rd_t  bib_rd_i,
	output      bop_pkg::bop_bib_rsp_t bib_rsp_o,
	// Received block write check
	input  wire bop_pkg::bop_blk_wr_t  blk_wr_i,
	output      logic                  ack_type_error_o,
	// Quadlet as seen by the serial bus
	output      logic [31:0]           bus_options_o
);
	import bop_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	bop_state_t  st;
	bop_state_t  next_st;
	logic [31:0] opt_word;
	logic [31:0] status_word;
	logic [31:0] control_word;
	logic [31:0] rd_data;
	logic        wr_en;
	logic        wr_opt;
	logic        wr_status;
	logic        wr_control;
	logic        oversize;
	logic        ack_err;
	logic        gen_bump;
	logic [1:0]  gen_base;
	logic        cfg_bad_now;
	logic        cnt_full;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	bop_wb_slave u_wb (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wb_req_i  (wb_req_i),
		.wb_rsp_o  (wb_rsp_o),
		.rd_data_i (rd_data),
		.wr_en_o   (wr_en)
	);

	// ------------------------------------------------------------
	// Length check on received block writes
	// ------------------------------------------------------------
	bop_len_check u_chk (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.mrec_i           (st.mrec),
		.chk_en_i         (st.chk_en),
		.blk_wr_i         (blk_wr_i),
		.ack_type_error_o (ack_err),
		.oversize_o       (oversize)
	);

	// ------------------------------------------------------------
	// Register images
	// ------------------------------------------------------------
	always_comb begin
		opt_word = 32'h0000_0000; // R9
		opt_word[`BOP_CAP_HI:`BOP_CAP_LO]   = st.caps; // R2 R3
		opt_word[`BOP_ACC_HI:`BOP_ACC_LO]   = st.acc; // R4
		opt_word[`BOP_MREC_HI:`BOP_MREC_LO] = st.mrec; // R6
		opt_word[`BOP_GEN_HI:`BOP_GEN_LO]   = st.gen; // R10
		opt_word[`BOP_SPD_HI:`BOP_SPD_LO]   = `BOP_LNK_SPD; // R11
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`BOP_ST_ROM_PEND] = st.rom_pend;
		status_word[`BOP_ST_LINK]     = link_active_control_i;
		status_word[`BOP_ST_CFG_BAD]  = st.cfg_bad;
		status_word[`BOP_ST_LEN_ERR]  = st.len_err;
		status_word[31:`BOP_ST_CNT_LO] = st.err_cnt;
	end

	always_comb begin
		control_word = 32'h0000_0000;
		control_word[`BOP_CTL_CHK_EN] = st.chk_en;
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Unmapped offsets still ack, reading zero and dropping writes
	always_comb begin
		case (wb_req_i.adr)
			`BOP_ADDR_BUS_OPTIONS: rd_data = opt_word;
			`BOP_ADDR_STATUS:      rd_data = status_word;
			`BOP_ADDR_CONTROL:     rd_data = control_word;
			default:               rd_data = 32'h0000_0000;
		endcase
	end

	assign wr_opt     = wr_en && (wb_req_i.adr == `BOP_ADDR_BUS_OPTIONS);
	assign wr_status  = wr_en && (wb_req_i.adr == `BOP_ADDR_STATUS);
	assign wr_control = wr_en && (wb_req_i.adr == `BOP_ADDR_CONTROL);

	// ------------------------------------------------------------
	// Generation counter support
	// ------------------------------------------------------------
	// A ROM change seen in the same cycle as the bus reset counts
	// toward the next bus reset; only a software or hardware reset drops a pending change.
	assign gen_bump = bus_reset_i && st.rom_pend; // R10

	// Software write and hardware bump in one cycle: bump the new value
	always_comb begin
		gen_base = st.gen;
		if (wr_opt && wb_req_i.sel[0]) begin
			gen_base = wb_req_i.dat[`BOP_GEN_HI:`BOP_GEN_LO];
		end
	end

	// ------------------------------------------------------------
	// Configuration sanity while the link is active
	// ------------------------------------------------------------
	// A code below 8 gives fewer than 512 bytes, which the bus forbids
	assign cfg_bad_now = link_active_control_i && (st.mrec < `BOP_MREC_MIN); // R5 R6
	assign cnt_full    = &st.err_cnt;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Byte lane 3: capability and power management flags
		if (wr_opt && wb_req_i.sel[3]) begin
			next_st.caps = wb_req_i.dat[`BOP_CAP_HI:`BOP_CAP_LO]; // R2 R3 R12
		end
		// Byte lane 2: clock accuracy
		if (wr_opt && wb_req_i.sel[2]) begin
			next_st.acc = wb_req_i.dat[`BOP_ACC_HI:`BOP_ACC_LO]; // R4
		end
		// Byte lane 1: max request, low nibble reserved
		if (wr_opt && wb_req_i.sel[1]) begin
			next_st.mrec = wb_req_i.dat[`BOP_MREC_HI:`BOP_MREC_LO]; // R6 R12
		end
		// Byte lane 0: generation only, speed bits are fixed
		next_st.gen = gen_bump ? gen_base + 2'h1 : gen_base; // R10 R12

		// Pending ROM change: set wins over the bus reset clear
		if (rom_change_i) begin
			next_st.rom_pend = 1'b1;
		end else if (bus_reset_i) begin
			next_st.rom_pend = 1'b0;
		end

		// Sticky flags, write one to clear, set wins
		if (wr_status && wb_req_i.sel[0] && wb_req_i.dat[`BOP_ST_CFG_BAD]) begin
			next_st.cfg_bad = 1'b0;
		end
		if (cfg_bad_now) begin
			next_st.cfg_bad = 1'b1;
		end
		if (wr_status && wb_req_i.sel[0] && wb_req_i.dat[`BOP_ST_LEN_ERR]) begin
			next_st.len_err = 1'b0;
		end
		if (oversize) begin
			next_st.len_err = 1'b1;
		end

		// Oversize counter saturates rather than wrapping to zero
		if (oversize && !cnt_full) begin
			next_st.err_cnt = st.err_cnt + 16'h0001;
		end

		if (wr_control && wb_req_i.sel[0]) begin
			next_st.chk_en = wb_req_i.dat[`BOP_CTL_CHK_EN];
		end

		// Remote quadlet read, answered one cycle later
		next_st.bib.ack  = bib_rd_i.req;
		next_st.bib.hit  = bib_rd_i.req && (bib_rd_i.qidx == `BOP_BIB_QIDX); // R1
		next_st.bib.data = 32'h0000_0000;
		if (bib_rd_i.req && (bib_rd_i.qidx == `BOP_BIB_QIDX)) begin
			next_st.bib.data = opt_word; // R1
		end

		// Software reset: all fields but the max request code and the remote read reply
		if (soft_rst_i) begin
			next_st.caps     = `BOP_RST_CAPS;
			next_st.acc      = `BOP_RST_ACC;
			next_st.gen      = `BOP_RST_GEN;
			next_st.rom_pend = 1'b0;
			next_st.cfg_bad  = 1'b0;
			next_st.len_err  = 1'b0;
			next_st.err_cnt  = 16'h0000;
			next_st.chk_en   = `BOP_RST_CHK_EN;
			next_st.mrec     = st.mrec; // R7
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st          <= '0;
			st.caps     <= `BOP_RST_CAPS;
			st.acc      <= `BOP_RST_ACC;
			st.mrec     <= `BOP_RST_MREC; // R7
			st.gen      <= `BOP_RST_GEN;
			st.chk_en   <= `BOP_RST_CHK_EN;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bib_rsp_o        = st.bib;
	assign ack_type_error_o = ack_err; // R8
	assign bus_options_o    = opt_word; // R1

endmodule : bop_bus_options

// ### bop_params.svh
`ifndef BOP_PARAMS_SVH
`define BOP_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BOP_ADDR_BUS_OPTIONS 8'h20
`define BOP_ADDR_STATUS      8'h40
`define BOP_ADDR_CONTROL     8'h44

// ----------------------------------------------------------------
// Bus options field positions
// ----------------------------------------------------------------
`define BOP_CAP_HI       31
`define BOP_CAP_LO       27
`define BOP_ACC_HI       23
`define BOP_ACC_LO       16
`define BOP_MREC_HI      15
`define BOP_MREC_LO      12
`define BOP_GEN_HI       7
`define BOP_GEN_LO       6
`define BOP_SPD_HI       2
`define BOP_SPD_LO       0

// ----------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------
`define BOP_ST_ROM_PEND  0
`define BOP_ST_LINK      1
`define BOP_ST_CFG_BAD   2
`define BOP_ST_LEN_ERR   3
`define BOP_ST_CNT_LO    16
`define BOP_CTL_CHK_EN   0

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define BOP_RST_CAPS     5'h00
`define BOP_RST_ACC      8'h00
`define BOP_RST_MREC     4'ha
`define BOP_RST_GEN      2'h0
`define BOP_RST_CHK_EN   1'b1
`define BOP_LNK_SPD      3'h2
`define BOP_MREC_MIN     4'h8
`define BOP_BIB_QIDX     3'h1

`endif

// ### bop_pkg.sv
package bop_pkg;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} bop_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} bop_wb_rsp_t;

	typedef struct packed {
		logic       req;
		logic [2:0] qidx;
	} bop_bib_rd_t;

	typedef struct packed {
		logic        ack;
		logic        hit;
		logic [31:0] data;
	} bop_bib_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] len;
	} bop_blk_wr_t;

	// ------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} bop_wb_state_t;

	typedef struct packed {
		logic err;
		logic over;
	} bop_chk_state_t;

	typedef struct packed {
		logic [4:0]   caps;
		logic [7:0]   acc;
		logic [3:0]   mrec;
		logic [1:0]   gen;
		logic         rom_pend;
		logic         cfg_bad;
		logic         len_err;
		logic [15:0]  err_cnt;
		logic         chk_en;
		bop_bib_rsp_t bib;
	} bop_state_t;

endpackage : bop_pkg

// ### bop_wb_slave.sv
`timescale 1ns/10ps

module bop_wb_slave (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone
	input  wire bop_pkg::bop_wb_req_t wb_req_i,
	output      bop_pkg::bop_wb_rsp_t wb_rsp_o,
	// Register file side
	input  wire logic [31:0]          rd_data_i,
	output      logic                 wr_en_o
);
	import bop_pkg::*;

	bop_wb_state_t st;
	bop_wb_state_t next_st;

	// One wait cycle; ack drops the cycle after it is given
	always_comb begin
		next_st     = st;
		next_st.ack = wb_req_i.cyc && wb_req_i.stb && !st.ack;
		if (next_st.ack) begin
			next_st.dat = rd_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Write lands at the same edge the master samples ack
	assign wr_en_o  = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && st.ack;
	assign wb_rsp_o = '{ack: st.ack, dat: st.dat};

endmodule : bop_wb_slave

// ### bop_len_check.sv
`timescale 1ns/10ps

module bop_len_check (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Configuration
	input  wire logic [3:0]           mrec_i,
	input  wire logic                 chk_en_i,
	// Incoming block write
	input  wire bop_pkg::bop_blk_wr_t blk_wr_i,
	// Results
	output      logic                 ack_type_error_o,
	output      logic                 oversize_o
);
	import bop_pkg::*;

	bop_chk_state_t st;
	bop_chk_state_t next_st;
	logic [16:0]    limit;
	logic           too_long;

	always_comb begin
		// Five-bit sum so code f gives 2^16 instead of wrapping to 2^0
		limit    = 17'h00001 << ({1'b0, mrec_i} + 5'h01); // R6
		too_long = blk_wr_i.valid && ({1'b0, blk_wr_i.len} > limit);
		next_st      = '0;
		next_st.over = too_long;
		next_st.err  = too_long && chk_en_i; // R8
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ack_type_error_o = st.err;
	assign oversize_o       = st.over;

endmodule : bop_len_check

// ### bop_bus_options_checker.sv
`timescale 1ns/10ps

module bop_bus_options_checker (
	// Watched top-level ports
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  soft_rst_i,
	input wire bop_pkg::bop_wb_req_t  wb_req_i,
	input wire bop_pkg::bop_wb_rsp_t  wb_rsp_o,
	input wire logic                  link_active_control_i,
	input wire logic                  rom_change_i,
	input wire logic                  bus_reset_i,
	input wire bop_pkg::bop_bib_rd_t  bib_rd_i,
	input wire bop_pkg::bop_bib_rsp_t bib_rsp_o,
	input wire bop_pkg::bop_blk_wr_t  blk_wr_i,
	input wire logic                  ack_type_error_o,
	input wire logic [31:0]           bus_options_o
);
	import bop_pkg::*;

	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_RSVD_ZERO: assert property (bus_options_o[26:24] == 3'h0
		&& bus_options_o[11:8] == 4'h0 && bus_options_o[5:3] == 3'h0)
		else $error("reserved bus options bits not zero");
	AST_LINK_SPEED: assert property (bus_options_o[2:0] == 3'h2)
		else $error("link speed field not 010");
	AST_BIB_HIT: assert property (bib_rd_i.req && bib_rd_i.qidx == 3'h1 |=> bib_rsp_o.ack
		&& bib_rsp_o.hit && bib_rsp_o.data == $past(bus_options_o))
		else $error("remote read of quadlet one wrong");
	AST_BIB_MISS: assert property (bib_rd_i.req && bib_rd_i.qidx != 3'h1 |=> bib_rsp_o.ack
		&& !bib_rsp_o.hit && bib_rsp_o.data == 32'h0)
		else $error("remote read of other quadlet not empty");
	AST_MREC_HW: assert property ($fell(rst_i) |-> bus_options_o[15:12] == 4'ha)
		else $error("max request code after hardware reset wrong");
	AST_SOFT_RST: assert property (soft_rst_i && !(wb_rsp_o.ack && wb_req_i.we) |=>
		bus_options_o[15:12] == $past(bus_options_o[15:12]) && bus_options_o[31:27] == 5'h0)
		else $error("software reset handled wrongly");
	AST_WB_ACK: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=>
		wb_rsp_o.ack ##1 !wb_rsp_o.ack)
		else $error("register bus ack not a one cycle pulse");
	AST_WR_LAND: assert property (wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == 8'h20
		&& wb_req_i.sel == 4'hf && !soft_rst_i && !bus_reset_i |=>
		bus_options_o == (($past(wb_req_i.dat) & 32'hf8fff0c0) | 32'h2))
		else $error("bus options write landed wrongly");
	AST_TYPE_ERR: assert property (ack_type_error_o |-> $past(blk_wr_i.valid)
		&& {16'h0, $past(blk_wr_i.len)} > (32'h1 << ($past(bus_options_o[15:12]) + 5'h1)))
		else $error("type error without oversize block");

endmodule : bop_bus_options_checker

bind bop_bus_options bop_bus_options_checker u_checker (
	.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o), .link_active_control_i(link_active_control_i),
	.rom_change_i(rom_change_i), .bus_reset_i(bus_reset_i), .bib_rd_i(bib_rd_i),
	.bib_rsp_o(bib_rsp_o), .blk_wr_i(blk_wr_i), .ack_type_error_o(ack_type_error_o),
	.bus_options_o(bus_options_o)
);

// ### bop_remote_node.sv
`timescale 1ns/10ps

module bop_remote_node (
	// Clock
	input  wire logic                  clk_i,
	// Bus info block read
	output      bop_pkg::bop_bib_rd_t  bib_rd_o,
	input  wire bop_pkg::bop_bib_rsp_t bib_rsp_i,
	// Received block write
	output      bop_pkg::bop_blk_wr_t  blk_wr_o,
	input  wire logic                  ack_type_error_i
);
	import bop_pkg::*;

	logic        rd_req;
	logic        wr_req;
	logic [2:0]  qidx;
	logic [15:0] len;
	logic [15:0] idle_pat;

	initial begin
		rd_req   = 1'b0;
		wr_req   = 1'b0;
		qidx     = 3'h0;
		len      = 16'h0;
		idle_pat = 16'h0;
	end

	// Idle fields churn so a stale header never looks valid
	always @(posedge clk_i) begin
		idle_pat <= idle_pat + 16'h3b5d;
	end
	assign bib_rd_o = '{req: rd_req, qidx: rd_req ? qidx : idle_pat[2:0]};
	assign blk_wr_o = '{valid: wr_req, len: wr_req ? len : idle_pat};

	task automatic read_quad(input logic [2:0] q, output bop_bib_rsp_t rsp);
		@(posedge clk_i);
		rd_req <= 1'b1;
		qidx   <= q;
		@(posedge clk_i);
		rd_req <= 1'b0;
		// Answer stands in the cycle after the request edge
		@(posedge clk_i);
		rsp = bib_rsp_i;
	endtask : read_quad

	task automatic send_block(input logic [15:0] n, output logic err);
		@(posedge clk_i);
		wr_req <= 1'b1;
		len    <= n;
		@(posedge clk_i);
		wr_req <= 1'b0;
		@(posedge clk_i);
		err = ack_type_error_i;
	endtask : send_block

endmodule : bop_remote_node

// ### bop_bus_options_tb.sv
`timescale 1ns/10ps

module bop_bus_options_tb;
	import bop_pkg::*;

	logic          clk_i;
	logic          rst_i;
	logic          soft_rst;
	logic          link_active;
	logic          rom_change;
	logic          bus_reset;
	bop_wb_req_t   wb_req;
	bop_wb_rsp_t   wb_rsp;
	bop_bib_rd_t   bib_rd;
	bop_bib_rsp_t  bib_rsp;
	bop_blk_wr_t   blk_wr;
	logic          ate;
	logic [31:0]   opt;
	bop_bib_rsp_t  bib;
	logic          err;
	logic [15:0]   max_len;
	logic [3:0]    codes[2] = '{4'h8, 4'he};
	int            miscompares = 0;
	int            total_checks = 0;
	int            cycle_cnt = 0;

	bop_bus_options u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst), .wb_req_i(wb_req),
		.wb_rsp_o(wb_rsp), .link_active_control_i(link_active), .rom_change_i(rom_change),
		.bus_reset_i(bus_reset), .bib_rd_i(bib_rd), .bib_rsp_o(bib_rsp), .blk_wr_i(blk_wr),
		.ack_type_error_o(ate), .bus_options_o(opt)
	);

	bop_remote_node u_node (
		.clk_i(clk_i), .bib_rd_o(bib_rd), .bib_rsp_i(bib_rsp), .blk_wr_o(blk_wr),
		.ack_type_error_i(ate)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Bench tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
			input logic [31:0] wdat, output logic [31:0] rdat);
		@(posedge clk_i);
		wb_req <= '{1'b1, 1'b1, we, sel, adr, wdat};
		// Waits however long; only the bench timeout ends a hang
		do begin
			@(posedge clk_i);
		end while (wb_rsp.ack !== 1'b1);
		rdat = wb_rsp.dat;
		wb_req <= '0;
	endtask : wb_cycle

	task automatic wr_sel(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		logic [31:0] d;
		wb_cycle(1'b1, adr, sel, dat, d);
	endtask : wr_sel

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wr_sel(adr, 4'hf, dat);
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		wb_cycle(1'b0, adr, 4'hf, 32'h0, d);
		check(name, d, exp);
	endtask : rd_chk

	task automatic ev(input logic rc, input logic br);
		@(posedge clk_i);
		rom_change <= rc;
		bus_reset  <= br;
		@(posedge clk_i);
		rom_change <= 1'b0;
		bus_reset  <= 1'b0;
	endtask : ev

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// Generous ceiling; the sequence needs under two hundred cycles
	always @(posedge clk_i) begin
		cycle_cnt++;
		if (cycle_cnt == 4000) begin
			miscompares++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		soft_rst = 1'b0;
		link_active = 1'b0;
		rom_change = 1'b0;
		bus_reset = 1'b0;
		wb_req = '0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("opt_reset", 8'h20, 32'h0000_a002);
		check("opt_pin", opt, 32'h0000_a002);
		u_node.read_quad(3'h1, bib);
		check("bib_data", bib.data, 32'h0000_a002);
		check("bib_ack", {31'h0, bib.ack}, 32'h1);
		$display("test reset done");
		// Fields stay valid from here on while the link is active
		link_active <= 1'b1;
		wr(8'h20, 32'hffff_ffff);
		rd_chk("opt_ones", 8'h20, 32'hf8ff_f0c2);
		u_node.read_quad(3'h1, bib);
		check("bib_ones", bib.data, 32'hf8ff_f0c2);
		for (int i = 27; i < 32; i++) begin
			wr(8'h20, (32'h1 << i) | 32'h0000_a000);
			rd_chk("cap_bit", 8'h20, (32'h1 << i) | 32'h0000_a002);
		end
		wr(8'h20, 32'h00a5_a000);
		rd_chk("accuracy", 8'h20, 32'h00a5_a002);
		// Only lane 2 enabled: caps, max request and generation keep their values
		wr_sel(8'h20, 4'h4, 32'hff5a_ffff);
		rd_chk("sel_lane", 8'h20, 32'h005a_a002);
		wr(8'h80, 32'hffff_ffff);
		rd_chk("unmapped", 8'h80, 32'h0);
		rd_chk("opt_kept", 8'h20, 32'h005a_a002);
		u_node.read_quad(3'h0, bib);
		check("bib_miss", {31'h0, bib.hit} | bib.data, 32'h0);
		$display("test fields done");
		wr(8'h20, 32'hffff_ffff);
		@(posedge clk_i);
		soft_rst <= 1'b1;
		@(posedge clk_i);
		soft_rst <= 1'b0;
		rd_chk("soft_rst", 8'h20, 32'h0000_f002);
		$display("test soft reset done");
		foreach (codes[k]) begin
			wr(8'h20, {16'h0, codes[k], 12'h000});
			max_len = 16'h1 << (codes[k] + 4'h1);
			u_node.send_block(max_len, err);
			check("len_at_max", {31'h0, err}, 32'h0);
			u_node.send_block(max_len + 16'h1, err);
			check("len_over", {31'h0, err}, 32'h1);
		end
		// Two oversize blocks so far: sticky flag, link bit and count of two
		rd_chk("status", 8'h40, 32'h0002_000a);
		wr(8'h40, 32'h0000_0008);
		rd_chk("status_w1c", 8'h40, 32'h0002_0002);
		wr(8'h44, 32'h0000_0000);
		rd_chk("control", 8'h44, 32'h0000_0000);
		u_node.send_block(16'h8001, err);
		check("len_chk_off", {31'h0, err}, 32'h0);
		rd_chk("status_cnt", 8'h40, 32'h0003_000a);
		$display("test max request done");
		wr(8'h20, 32'h0000_a0c0);
		rd_chk("gen_set", 8'h20, 32'h0000_a0c2);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		rd_chk("gen_wrap", 8'h20, 32'h0000_a002);
		ev(1'b0, 1'b1);
		rd_chk("gen_hold", 8'h20, 32'h0000_a002);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b1);
		rd_chk("gen_bump", 8'h20, 32'h0000_a042);
		$display("test generation done");
		wr(8'h20, 32'h0000_8000);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("hw_rst", 8'h20, 32'h0000_a002);
		$display("test hardware reset done");
		give_verdict();
	end

endmodule : bop_bus_options_tb
